//--- fsc_checker.sv
// fsc_checker: pin-level timing checks for fsc_flash_ctrl.
// assumes one clk domain with synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module fsc_checker #(
    parameter logic [31:0] SECTOR_ERASE_CYCLES = fsc_pkg::SECTOR_ERASE_CYCLES,
    parameter logic [31:0] CHIP_ERASE_CYCLES   = fsc_pkg::CHIP_ERASE_CYCLES,
    parameter logic [31:0] STATUS_WRITE_CYCLES = fsc_pkg::STATUS_WRITE_CYCLES
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 sck,
    input wire logic                 cs_n,
    input wire logic                 si,
    input wire logic                 wp_n,
    input wire logic                 so,
    input wire logic                 so_oe,
    input wire logic                 busy,
    input wire fsc_pkg::fsc_status_t status,
    input wire fsc_pkg::fsc_erase_t  erase
);
    logic [31:0] busy_cnt_ff;
    logic [31:0] busy_lim_ff;

    // length of the current busy stretch
    always_ff @(posedge clk) begin
        if (rst || !busy)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end

    // expected length, chosen when busy starts
    always_ff @(posedge clk) begin
        if (rst)
            busy_lim_ff <= 32'h0;
        else if (busy && busy_cnt_ff == 32'h0)
            busy_lim_ff <= erase.req ? (erase.all ? CHIP_ERASE_CYCLES : SECTOR_ERASE_CYCLES)
                                     : STATUS_WRITE_CYCLES;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_busy_mirror; busy == status.busy; endproperty
    property p_req_busy; erase.req |-> busy; endproperty
    property p_req_wel; erase.req |-> $past(status.write_enable_latch); endproperty
    property p_req_cs; erase.req |-> cs_n && $past(cs_n, 3); endproperty
    property p_chip_free; erase.req && erase.all |-> status.block_protect == 3'h0; endproperty
    property p_reserved; status.reserved == 2'h0; endproperty
    property p_lock_hold;
        $past(status.protect_lock_bit) && !wp_n && $past(!wp_n, 8) |->
            status.protect_lock_bit && $stable(status.block_protect);
    endproperty
    property p_busy_len;
        $fell(busy) |-> busy_cnt_ff >= busy_lim_ff - 32'h1 && busy_cnt_ff <= busy_lim_ff + 32'h1;
    endproperty
    property p_wel_end; $fell(busy) |-> !status.write_enable_latch; endproperty
    property p_so_quiet; cs_n && $past(cs_n, 8) |-> !so_oe; endproperty

    a_busy_mirror: assert property (p_busy_mirror)
        else $error("busy pin differs from status busy");
    a_req_busy: assert property (p_req_busy)
        else $error("erase request without busy");
    a_req_wel: assert property (p_req_wel)
        else $error("erase request without write enable latch");
    a_req_cs: assert property (p_req_cs)
        else $error("erase request while chip select low");
    a_chip_free: assert property (p_chip_free)
        else $error("chip erase while protected");
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits changed");
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked status changed with write protect low");
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    a_wel_end: assert property (p_wel_end)
        else $error("write enable latch still set after cycle");
    a_so_quiet: assert property (p_so_quiet)
        else $error("output driven while deselected");

    c_sector: cover property (erase.req && !erase.all);
    c_chip: cover property (erase.req && erase.all);
    c_lock: cover property ($rose(status.protect_lock_bit));
endmodule
bind fsc_flash_ctrl fsc_checker #(
    .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
    .CHIP_ERASE_CYCLES  (CHIP_ERASE_CYCLES),
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) u_chk (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so),
         .so_oe(so_oe), .busy(busy), .status(status), .erase(erase));
`default_nettype wire

//--- fsc_flash_ctrl.sv
// fsc_flash_ctrl: serial command front end for erase, status read,
// write-enable latch and status write with protect lockdown.
// assumes host pins are asynchronous to clk and sck is far slower than clk.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - opcode 20h plus 24-bit address requests erase of one 4k sector
// - sector taken from address bit 19 down to bit 12, bits above 19 and below 12 ignored
// - finished sector erase sets that sector to ffh, others untouched
// - sector erase into a protected region is dropped
// - program and erase refused unless the write-enable latch is set
// - erase starts only when chip select rises after the full sequence
// - chip erase by opcode 60h or c7h, no address
// - finished chip erase sets every byte to ffh
// - chip erase dropped if any region is protected
// - erases self-timed, completion seen on the busy flag
// - status read accepted at any time, even while busy
// - status byte repeats on every further clock until chip select rises
// - host polls busy before new commands during an internal write
// - latch-set command sets the write-enable latch at chip select rise
// - latch-clear command clears the write-enable latch at chip select rise
// - arming only counts when the very next command is a status write
// - status write changes only three protect bits and the lock bit
// - status write ignored while write-protect low and lock bit is one
// - with write-protect low the lock bit may only go zero to one
// - permission checked at chip select rise: lock zero or pin high
// - one permitted write may set lock and change protect bits together
module fsc_flash_ctrl #(
    parameter logic [31:0] SECTOR_ERASE_CYCLES = fsc_pkg::SECTOR_ERASE_CYCLES,
    parameter logic [31:0] CHIP_ERASE_CYCLES   = fsc_pkg::CHIP_ERASE_CYCLES,
    parameter logic [31:0] STATUS_WRITE_CYCLES = fsc_pkg::STATUS_WRITE_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                sck,
    input  wire logic                cs_n,
    input  wire logic                si,
    input  wire logic                wp_n,
    output var  logic                so,
    output var  logic                so_oe,
    output var  logic                busy,
    output var  fsc_pkg::fsc_status_t status,
    output var  fsc_pkg::fsc_erase_t  erase
);

    fsc_pkg::fsc_pins_t   pins_raw;
    logic [3:0]           sync1_ff;
    logic [3:0]           sync2_ff;
    logic [3:0]           sync3_ff;
    fsc_pkg::fsc_pins_t   filt_ff;
    fsc_pkg::fsc_pins_t   prev_ff;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cs_fall;
    logic                 cs_rise;
    logic [5:0]           bit_cnt_ff;
    logic [31:0]          shift_ff;
    logic [7:0]           opcode_ff;
    logic                 reading_ff;
    logic [2:0]           out_idx_ff;
    logic [7:0]           snap_ff;
    logic                 so_ff;
    logic                 so_oe_ff;
    fsc_pkg::fsc_status_t status_ff;
    logic                 busy_ff;
    logic                 wel_ff;
    logic                 lock_ff;
    logic [2:0]           bp_ff;
    logic                 armed_ff;
    fsc_pkg::fsc_op_t     op_ff;
    logic [31:0]          timer_ff;
    fsc_pkg::fsc_erase_t  erase_ff;
    logic [fsc_pkg::SECTOR_W-1:0] sector_sel;
    logic                 len_opcode;
    logic                 may_write;
    logic                 exec_latch_set;
    logic                 exec_latch_clear;
    logic                 exec_arm;
    logic                 exec_sector;
    logic                 exec_chip;
    logic                 exec_swrite;
    logic                 cycle_done;

    // protected region: top blocks of the array, grows with the setting
    function automatic logic sector_protected(
        input logic [2:0]                   bp,
        input logic [fsc_pkg::SECTOR_W-1:0] sec
    );
        logic [fsc_pkg::BLOCK_W-1:0] blk;
        blk = sec[fsc_pkg::SECTOR_W-1 -: fsc_pkg::BLOCK_W];
        case (bp)
            3'h0:    sector_protected = 1'b0;
            3'h1:    sector_protected = (blk >= 4'hf);
            3'h2:    sector_protected = (blk >= 4'he);
            3'h3:    sector_protected = (blk >= 4'hc);
            3'h4:    sector_protected = (blk >= 4'h8);
            default: sector_protected = 1'b1;
        endcase
    endfunction

    assign pins_raw.sck  = sck;
    assign pins_raw.cs_n = cs_n;
    assign pins_raw.si   = si;
    assign pins_raw.wp_n = wp_n;

    // three-stage synchroniser per pin
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= fsc_pkg::PINS_RESET;
            sync2_ff <= fsc_pkg::PINS_RESET;
            sync3_ff <= fsc_pkg::PINS_RESET;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a pin change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            always_ff @(posedge clk) begin
                if (rst) begin
                    filt_ff[gi] <= fsc_pkg::PINS_RESET[gi];
                    prev_ff[gi] <= fsc_pkg::PINS_RESET[gi];
                end else begin
                    if (sync2_ff[gi] == sync3_ff[gi]) begin
                        filt_ff[gi] <= sync3_ff[gi];
                    end
                    prev_ff[gi] <= filt_ff[gi];
                end
            end
        end
    endgenerate

    assign sck_rise = filt_ff.sck & ~prev_ff.sck & ~filt_ff.cs_n;
    assign sck_fall = ~filt_ff.sck & prev_ff.sck & ~filt_ff.cs_n;
    assign cs_fall  = ~filt_ff.cs_n & prev_ff.cs_n;
    assign cs_rise  = filt_ff.cs_n & ~prev_ff.cs_n;

    // input shifter, msb first on sck rise
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt_ff <= 6'h00;
            shift_ff   <= 32'h0000_0000;
            opcode_ff  <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_ff <= 6'h00;
        end else if (sck_rise) begin
            shift_ff <= {shift_ff[30:0], filt_ff.si};
            if (bit_cnt_ff != fsc_pkg::BITS_MAX) begin
                bit_cnt_ff <= bit_cnt_ff + 6'h01;
            end
            if (bit_cnt_ff == fsc_pkg::BITS_OPCODE - 6'h01) begin
                opcode_ff <= {shift_ff[6:0], filt_ff.si};
            end
        end
    end

    // status read: decoded even while busy, byte repeats until deselect
    always_ff @(posedge clk) begin
        if (rst) begin
            reading_ff <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            reading_ff <= 1'b0;
        end else if (sck_rise && bit_cnt_ff == fsc_pkg::BITS_OPCODE - 6'h01 &&
                     {shift_ff[6:0], filt_ff.si} == fsc_pkg::OP_STATUS_READ) begin
            reading_ff <= 1'b1;
        end
    end

    // output shifter on sck fall; fresh status snapshot per byte
    always_ff @(posedge clk) begin
        if (rst) begin
            out_idx_ff <= 3'h0;
            snap_ff    <= 8'h00;
            so_ff      <= 1'b0;
            so_oe_ff   <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            out_idx_ff <= 3'h0;
            so_oe_ff   <= 1'b0;
        end else if (sck_fall && reading_ff) begin
            so_oe_ff   <= 1'b1;
            out_idx_ff <= out_idx_ff + 3'h1;
            if (out_idx_ff == 3'h0) begin
                snap_ff <= status_ff;
                so_ff   <= status_ff[fsc_pkg::OUT_BIT_LAST];
            end else begin
                so_ff   <= snap_ff[fsc_pkg::OUT_BIT_LAST - out_idx_ff];
            end
        end
    end

    // command decode, all executed on the closing chip select edge
    assign sector_sel = shift_ff[fsc_pkg::ADDR_MSB:fsc_pkg::SECTOR_LSB];
    assign len_opcode = (bit_cnt_ff == fsc_pkg::BITS_OPCODE);
    assign may_write  = status_ff.write_enable_latch & ~status_ff.busy;

    assign exec_latch_set   = cs_rise & ~status_ff.busy & len_opcode &
                              (opcode_ff == fsc_pkg::OP_LATCH_SET);
    assign exec_latch_clear = cs_rise & ~status_ff.busy & len_opcode &
                              (opcode_ff == fsc_pkg::OP_LATCH_CLEAR);
    assign exec_arm         = cs_rise & ~status_ff.busy & len_opcode &
                              (opcode_ff == fsc_pkg::OP_STATUS_WRITE_ARM);
    assign exec_sector      = cs_rise & may_write &
                              (bit_cnt_ff == fsc_pkg::BITS_SECTOR_ERASE) &
                              (opcode_ff == fsc_pkg::OP_SECTOR_ERASE) &
                              ~sector_protected(status_ff.block_protect,
                                                sector_sel);
    assign exec_chip        = cs_rise & may_write & len_opcode &
                              ((opcode_ff == fsc_pkg::OP_CHIP_ERASE_A) |
                               (opcode_ff == fsc_pkg::OP_CHIP_ERASE_B)) &
                              (status_ff.block_protect == 3'h0);
    assign exec_swrite      = cs_rise & ~status_ff.busy &
                              (bit_cnt_ff == fsc_pkg::BITS_STATUS_WRITE) &
                              (opcode_ff == fsc_pkg::OP_STATUS_WRITE) &
                              (armed_ff | status_ff.write_enable_latch) &
                              ~(~filt_ff.wp_n & status_ff.protect_lock_bit);

    // arming lives for exactly one following command
    always_ff @(posedge clk) begin
        if (rst) begin
            armed_ff <= 1'b0;
        end else if (cs_rise && bit_cnt_ff != 6'h00) begin
            armed_ff <= exec_arm;
        end
    end

    // internal self-timed cycle
    assign cycle_done = (op_ff != fsc_pkg::OP_IDLE) && (timer_ff == 32'h0000_0001);

    // which operation is running
    always_ff @(posedge clk) begin
        if (rst) begin
            op_ff <= fsc_pkg::OP_IDLE;
        end else begin
            case (op_ff)
                fsc_pkg::OP_IDLE: begin
                    if (exec_sector) begin
                        op_ff <= fsc_pkg::OP_SECTOR;
                    end else if (exec_chip) begin
                        op_ff <= fsc_pkg::OP_CHIP;
                    end else if (exec_swrite) begin
                        op_ff <= fsc_pkg::OP_SWRITE;
                    end
                end
                fsc_pkg::OP_SECTOR, fsc_pkg::OP_CHIP, fsc_pkg::OP_SWRITE: begin
                    if (cycle_done) begin
                        op_ff <= fsc_pkg::OP_IDLE;
                    end
                end
                default: begin
                    op_ff <= fsc_pkg::OP_IDLE;
                end
            endcase
        end
    end

    // cycle length counter, loaded at launch
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_ff <= 32'h0000_0000;
        end else if (op_ff == fsc_pkg::OP_IDLE) begin
            if (exec_sector) begin
                timer_ff <= SECTOR_ERASE_CYCLES;
            end else if (exec_chip) begin
                timer_ff <= CHIP_ERASE_CYCLES;
            end else if (exec_swrite) begin
                timer_ff <= STATUS_WRITE_CYCLES;
            end
        end else begin
            timer_ff <= timer_ff - 32'h0000_0001;
        end
    end

    // request to the array: pulse with the target, array fills with ff
    always_ff @(posedge clk) begin
        if (rst) begin
            erase_ff <= fsc_pkg::ERASE_RESET;
        end else begin
            erase_ff.req <= exec_sector | exec_chip;
            if (exec_sector) begin
                erase_ff.all          <= 1'b0;
                erase_ff.sector_index <= sector_sel;
            end else if (exec_chip) begin
                erase_ff.all          <= 1'b1;
                erase_ff.sector_index <= '0;
            end
        end
    end

    // busy flag: set at launch, dropped when the cycle ends
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_ff <= fsc_pkg::STATUS_RESET.busy;
        end else if (exec_sector || exec_chip || exec_swrite) begin
            busy_ff <= 1'b1;
        end else if (cycle_done) begin
            busy_ff <= 1'b0;
        end
    end

    // write-enable latch
    always_ff @(posedge clk) begin
        if (rst) begin
            wel_ff <= fsc_pkg::STATUS_RESET.write_enable_latch;
        end else if (exec_latch_set) begin
            wel_ff <= 1'b1;
        end else if (exec_latch_clear || cycle_done) begin
            wel_ff <= 1'b0;
        end
    end

    // protect bits; lock can only fall while pin high, writes refused while lock set and pin low
    always_ff @(posedge clk) begin
        if (rst) begin
            bp_ff   <= fsc_pkg::STATUS_RESET.block_protect;
            lock_ff <= fsc_pkg::STATUS_RESET.protect_lock_bit;
        end else if (exec_swrite) begin
            bp_ff   <= shift_ff[4:2];
            lock_ff <= shift_ff[7];
        end
    end

    // status byte, reserved bits read as zero
    assign status_ff = {lock_ff, 2'h0, bp_ff, wel_ff, busy_ff};

    assign so     = so_ff;
    assign so_oe  = so_oe_ff;
    assign busy   = status_ff.busy;
    assign status = status_ff;
    assign erase  = erase_ff;

endmodule

`default_nettype wire

//--- fsc_host_model.sv
// fsc_host_model: serial host, mode 0, 80 ns sck, one command per frame.
// assumes clk at 100 MHz; all pin changes at clk falling edges.
`timescale 1ns/1ns
`default_nettype none
module fsc_host_model (
    input  wire logic clk,
    input  wire logic so,
    input  wire logic so_oe,
    output var  logic sck,
    output var  logic cs_n,
    output var  logic si
);
    logic        last_n;
    logic [15:0] rd;
    // released line shows the inverse of the last bit seen
    wire logic line = so_oe ? so : last_n;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        last_n = 1'b0;
        rd = 16'h0;
    end

    // shifts n bits from d msb first; bits after the 8th are read back
    task automatic frame(input logic [31:0] d, input int n);
        int i;
        cs_n <= 1'b0;
        repeat (4) @(negedge clk);
        for (i = 0; i < n; i++) begin
            repeat (2) @(negedge clk);
            si <= d[31-i];
            repeat (2) @(negedge clk);
            sck <= 1'b1;
            repeat (4) @(negedge clk);
            if (i >= 8) begin
                rd = {rd[14:0], line};
                last_n = ~line;
            end
            sck <= 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n <= 1'b1;
        repeat (30) @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- fsc_pkg.sv
// fsc_pkg: constants, status layout and carriers for the serial flash
// erase/status command block; shared by the design and its bench.
package fsc_pkg;

    // opcodes
    localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
    localparam logic [7:0] OP_CHIP_ERASE_A     = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B     = 8'hc7;
    localparam logic [7:0] OP_STATUS_READ      = 8'h05;
    localparam logic [7:0] OP_LATCH_SET        = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR      = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
    localparam logic [7:0] OP_STATUS_WRITE     = 8'h01;

    // frame lengths in bits, opcode included
    localparam logic [5:0] BITS_OPCODE       = 6'h08;
    localparam logic [5:0] BITS_STATUS_WRITE = 6'h10;
    localparam logic [5:0] BITS_SECTOR_ERASE = 6'h20;
    localparam logic [5:0] BITS_MAX          = 6'h3f;

    // address layout
    localparam int         ADDR_MSB     = 19;
    localparam int         SECTOR_LSB   = 12;
    localparam int         SECTOR_W     = 8;
    localparam int         BLOCK_W      = 4;
    localparam logic [2:0] OUT_BIT_LAST = 3'h7;

    // self-timed cycle lengths (worst case)
    localparam longint unsigned CLK_MHZ               = 100;
    localparam longint unsigned SECTOR_ERASE_TIME_US  = 120000;
    localparam longint unsigned CHIP_ERASE_TIME_US    = 30000000;
    localparam longint unsigned STATUS_WRITE_TIME_US  = 10;
    localparam logic [31:0] SECTOR_ERASE_CYCLES = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] CHIP_ERASE_CYCLES   = 32'(CHIP_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] STATUS_WRITE_CYCLES = 32'(STATUS_WRITE_TIME_US * CLK_MHZ);

    // status byte, msb first on the wire
    typedef struct packed {
        logic       protect_lock_bit;
        logic [1:0] reserved;
        logic [2:0] block_protect;     // [2] two, [1] one, [0] zero
        logic       write_enable_latch;
        logic       busy;
    } fsc_status_t;

    localparam fsc_status_t STATUS_RESET = 8'h00;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic wp_n;
    } fsc_pins_t;

    localparam fsc_pins_t PINS_RESET = 4'h4;

    // request to the array: pulse plus what to clear to ff
    typedef struct packed {
        logic                req;
        logic                all;
        logic [SECTOR_W-1:0] sector_index;
    } fsc_erase_t;

    localparam fsc_erase_t ERASE_RESET = 10'h000;

    typedef enum {
        OP_IDLE,
        OP_SECTOR,
        OP_CHIP,
        OP_SWRITE
    } fsc_op_t;

endpackage

//--- testbench.sv
// testbench: command sequences through the serial host model.
// assumes shortened erase and status write cycle counts.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [31:0] SE = 32'h190;
    localparam logic [31:0] CE = 32'h1f4;
    localparam logic [31:0] SW = 32'h14;
    logic                 clk;
    logic                 rst;
    logic                 wp_n;
    wire logic            sck, cs_n, si, so, so_oe, busy;
    wire fsc_pkg::fsc_status_t status;
    wire fsc_pkg::fsc_erase_t  erase;
    fsc_pkg::fsc_erase_t  last_req = fsc_pkg::ERASE_RESET;
    int                   mismatches = 0;
    int                   comparisons = 0;
    int                   req_cnt = 0;

    fsc_flash_ctrl #(.SECTOR_ERASE_CYCLES(SE), .CHIP_ERASE_CYCLES(CE), .STATUS_WRITE_CYCLES(SW))
        DUT (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so),
             .so_oe(so_oe), .busy(busy), .status(status), .erase(erase));
    fsc_host_model host (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (erase.req === 1'b1) begin
            req_cnt++;
            last_req = erase;
        end
    end

    task automatic wrap_up;
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_req(input logic [3:0] n, input logic a);
        chk("erase", {11'h0, a, n}, {11'h0, last_req.all, req_cnt[3:0]});
    endtask

    task automatic cmd(input logic [7:0] op);
        host.frame({op, 24'h0}, 8);
    endtask

    // status byte twice in one frame
    task automatic stat(input logic [7:0] exp);
        host.frame({fsc_pkg::OP_STATUS_READ, 24'h0}, 24);
        chk("status", {exp, exp}, host.rd);
    endtask

    task automatic wait_ready;
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            host.frame({fsc_pkg::OP_STATUS_READ, 24'h0}, 24);
        chk("ready", 16'h0, {15'h0, busy});
    endtask

    task automatic wr_status(input logic [7:0] d);
        cmd(fsc_pkg::OP_STATUS_WRITE_ARM);
        host.frame({fsc_pkg::OP_STATUS_WRITE, d, 16'h0}, 16);
        wait_ready;
    endtask

    task automatic sector(input logic [23:0] a);
        host.frame({fsc_pkg::OP_SECTOR_ERASE, a}, 32);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        wrap_up;
    end

    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset", 16'h0, {status, 7'h0, busy});
        sector(24'h0a5fff);
        chk_req(4'h0, 1'b0);
        cmd(fsc_pkg::OP_LATCH_SET);
        stat(8'h02);
        cmd(fsc_pkg::OP_LATCH_CLEAR);
        stat(8'h00);
        cmd(fsc_pkg::OP_LATCH_SET);
        sector(24'h0a5fff);
        chk_req(4'h1, 1'b0);
        chk("sector", 16'h00a5, {8'h0, last_req.sector_index});
        stat(8'h03);
        wait_ready;
        stat(8'h00);
        for (int k = 0; k < 2; k++) begin
            cmd(fsc_pkg::OP_LATCH_SET);
            cmd(k == 0 ? fsc_pkg::OP_CHIP_ERASE_A : fsc_pkg::OP_CHIP_ERASE_B);
            chk_req(4'(2 + k), 1'b1);
            wait_ready;
            stat(8'h00);
        end
        cmd(fsc_pkg::OP_STATUS_WRITE_ARM);
        stat(8'h00);
        host.frame({fsc_pkg::OP_STATUS_WRITE, 8'h9c, 16'h0}, 16);
        stat(8'h00);
        wr_status(8'h7e);
        stat(8'h1c);
        wr_status(8'h04);
        stat(8'h04);
        cmd(fsc_pkg::OP_LATCH_SET);
        sector(24'h0f3000);
        chk_req(4'h3, 1'b1);
        cmd(fsc_pkg::OP_CHIP_ERASE_A);
        chk_req(4'h3, 1'b1);
        sector(24'h013abc);
        chk_req(4'h4, 1'b0);
        chk("sector", 16'h0013, {8'h0, last_req.sector_index});
        wait_ready;
        wp_n = 1'b0;
        wr_status(8'h88);
        stat(8'h88);
        wr_status(8'h00);
        stat(8'h88);
        wp_n = 1'b1;
        repeat (8) @(negedge clk);
        wr_status(8'h00);
        stat(8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
